// File: flash_timer_pkg.sv
// Constants for the flash program/erase strobe sequencer.
// Assumes a single 40 MHz system clock; all counts are in clock cycles.
package flash_timer_pkg;

  // Register field widths
  localparam int PRESCALE_W   = 8;   // Shared prescaler count width
  localparam int PHASE_W      = 8;   // Per-phase count width
  localparam int MULT_W       = 12;  // Fixed multiplier stage width

  // Fixed multiplier factors, stored as terminal counts
  localparam logic [MULT_W-1:0] MULT_ONE  = 12'h000; // Factor 1
  localparam logic [MULT_W-1:0] MULT_8    = 12'h007; // Factor 8
  localparam logic [MULT_W-1:0] MULT_4096 = 12'hfff; // Factor 4096

  // Reset values of the count registers
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 8'h00;
  localparam logic [PHASE_W-1:0]    PHASE_RST    = 8'h00;

  // Register set index in the count memory
  localparam int SET_MAIN = 0;  // Program array set
  localparam int SET_DATA = 1;  // Data array set

  // Operation codes
  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_PAGE_ERASE,
    OP_MODULE_ERASE
  } op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_TRAN,
    ST_PULSE,
    ST_HOLD,
    ST_RECOVER
  } seq_state_t;

endpackage : flash_timer_pkg

// File: phase_timer.sv
// Cascaded prescaler, multiplier and phase counter for one timed phase.
// Assumes counts stay stable from start until done.
`timescale 1ns/100ps
module phase_timer (
  // Clock and reset
  input  wire logic                                i_core_clk,
  input  wire logic                                i_rst_n,
  // Control
  input  wire logic                                i_start,
  input  wire logic [flash_timer_pkg::PRESCALE_W-1:0] i_prescale,
  input  wire logic [flash_timer_pkg::MULT_W-1:0]  i_mult,
  input  wire logic [flash_timer_pkg::PHASE_W-1:0] i_count,
  // Status
  output logic                                     o_done
);

  logic [flash_timer_pkg::PRESCALE_W-1:0] pre_q;   // Prescaler
  logic [flash_timer_pkg::MULT_W-1:0]     mult_q;  // Fixed factor stage
  logic [flash_timer_pkg::PHASE_W-1:0]    phase_q; // Phase counter
  logic                                   run_q;   // Timer active

  // Wrap strobes of each stage
  wire pre_wrap   = run_q && (pre_q == i_prescale);
  wire mult_wrap  = pre_wrap && (mult_q == i_mult);
  wire phase_last = mult_wrap && (phase_q == i_count);

  // Prescaler counting 0..prescale, cascaded into the phase counter
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q   <= '0;
      mult_q  <= '0;
      phase_q <= '0;
      run_q   <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= phase_last;
      if (i_start) begin
        // Restart clears every stage
        pre_q   <= '0;
        mult_q  <= '0;
        phase_q <= '0;
        run_q   <= 1'b1;
      end else if (run_q) begin
        pre_q <= pre_wrap ? '0 : pre_q + 1'b1;
        if (pre_wrap) begin
          mult_q <= mult_wrap ? '0 : mult_q + 1'b1;
        end
        if (mult_wrap) begin
          phase_q <= phase_q + 1'b1;
        end
        if (phase_last) begin
          run_q <= 1'b0;
        end
      end
    end
  end

endmodule : phase_timer

// File: flash_program_erase_timer.sv
// Flash program/erase strobe sequencer with two timing register sets.
// Assumes the count ports are held stable by software during a run.
//
// Summary of operation
// - Setup delay: prescale+1 times setup+1 cycles
// - Strobe-to-pulse: prescale+1 times transition+1
// - Program pulse: prescale+1 times 8 times count+1
// - Page erase: prescale+1 times 4096 times count+1
// - Module erase: prescale+1 times 4096 times count+1
// - Program/page hold: prescale+1 times hold+1
// - Module hold: prescale+1 times 8 times count+1
// - Recovery: prescale+1 times recovery+1 cycles
// - Selected set supplies prescaler and counts
`timescale 1ns/100ps
module flash_program_erase_timer (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  // Command
  input  wire logic       i_start,      // One-cycle start request
  input  wire logic [1:0] i_op,         // Operation code
  input  wire logic       i_data_array, // High selects data-array set
  // Program-array counts
  input  wire logic [7:0] i_main_prescale_reg,
  input  wire logic [7:0] i_main_strobe_setup_reg,
  input  wire logic [7:0] i_main_pulse_setup_reg,
  input  wire logic [7:0] i_main_program_pulse_reg,
  input  wire logic [7:0] i_main_page_erase_reg,
  input  wire logic [7:0] i_main_module_erase_reg,
  input  wire logic [7:0] i_main_strobe_hold_reg,
  input  wire logic [7:0] i_main_module_hold_reg,
  input  wire logic [7:0] i_main_recovery_reg,
  // Data-array counts
  input  wire logic [7:0] i_data_prescale_reg,
  input  wire logic [7:0] i_data_strobe_setup_reg,
  input  wire logic [7:0] i_data_pulse_setup_reg,
  input  wire logic [7:0] i_data_program_pulse_reg,
  input  wire logic [7:0] i_data_page_erase_reg,
  input  wire logic [7:0] i_data_module_erase_reg,
  input  wire logic [7:0] i_data_strobe_hold_reg,
  input  wire logic [7:0] i_data_module_hold_reg,
  input  wire logic [7:0] i_data_recovery_reg,
  // Flash array controls
  output logic            o_program,
  output logic            o_erase,
  output logic            o_module_erase,
  output logic            o_nonvolatile_store_strobe,
  output logic            o_data_array_sel,
  // Status
  output logic            o_busy,
  output logic            o_done
);

  // Reset synchroniser; first stage read only by the second
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  flash_timer_pkg::seq_state_t state_q; // Sequencer state
  logic [1:0] op_q;       // Latched operation
  logic       set_q;      // Latched register set
  logic       tstart_q;   // Timer restart pulse
  wire        tdone;      // Timer expiry

  // Operation decode of the latched code; op_ok checks the incoming i_op
  wire is_prog   = (op_q == 2'(flash_timer_pkg::OP_PROGRAM));
  wire is_module = (op_q == 2'(flash_timer_pkg::OP_MODULE_ERASE));
  wire op_ok     = (i_op == 2'(flash_timer_pkg::OP_PROGRAM))
                || (i_op == 2'(flash_timer_pkg::OP_PAGE_ERASE))
                || (i_op == 2'(flash_timer_pkg::OP_MODULE_ERASE));

  // Counts of the selected set
  function automatic logic [7:0] pick(input logic s,
                                      input logic [7:0] m,
                                      input logic [7:0] d);
    pick = s ? d : m;
  endfunction : pick

  wire [7:0] prescale  = pick(set_q, i_main_prescale_reg,
                              i_data_prescale_reg);
  wire [7:0] c_setup   = pick(set_q, i_main_strobe_setup_reg,
                              i_data_strobe_setup_reg);
  wire [7:0] c_tran    = pick(set_q, i_main_pulse_setup_reg,
                              i_data_pulse_setup_reg);
  wire [7:0] c_prog    = pick(set_q, i_main_program_pulse_reg,
                              i_data_program_pulse_reg);
  wire [7:0] c_perase  = pick(set_q, i_main_page_erase_reg,
                              i_data_page_erase_reg);
  wire [7:0] c_merase  = pick(set_q, i_main_module_erase_reg,
                              i_data_module_erase_reg);
  wire [7:0] c_hold    = pick(set_q, i_main_strobe_hold_reg,
                              i_data_strobe_hold_reg);
  wire [7:0] c_mhold   = pick(set_q, i_main_module_hold_reg,
                              i_data_module_hold_reg);
  wire [7:0] c_rcv     = pick(set_q, i_main_recovery_reg,
                              i_data_recovery_reg);

  // Pulse and end (hold) counts and factors by operation
  wire [7:0]  c_pulse = is_prog ? c_prog
                      : (is_module ? c_merase : c_perase);
  wire [11:0] m_pulse = is_prog ? flash_timer_pkg::MULT_8
                      : flash_timer_pkg::MULT_4096;
  wire [7:0]  c_end   = is_module ? c_mhold : c_hold;
  wire [11:0] m_end   = is_module ? flash_timer_pkg::MULT_8
                      : flash_timer_pkg::MULT_ONE;

  // Phase timer count selection by state
  logic [7:0]  phase_cnt;
  logic [11:0] phase_mult;
  always_comb begin
    phase_cnt  = c_rcv;
    phase_mult = flash_timer_pkg::MULT_ONE;
    case (state_q)
      flash_timer_pkg::ST_SETUP: phase_cnt = c_setup;
      flash_timer_pkg::ST_TRAN:  phase_cnt = c_tran;
      flash_timer_pkg::ST_PULSE: begin
        phase_cnt  = c_pulse;
        phase_mult = m_pulse;
      end
      flash_timer_pkg::ST_HOLD: begin
        phase_cnt  = c_end;
        phase_mult = m_end;
      end
      default:   phase_cnt = c_rcv;
    endcase
  end

  // Shared timer, restarted at every phase entry
  phase_timer u_timer (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n_q),
    .i_start    (tstart_q),
    .i_prescale (prescale),
    .i_mult     (phase_mult),
    .i_count    (phase_cnt),
    .o_done     (tdone)
  );

  // Phase sequencer
  always_ff @(posedge i_core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q  <= flash_timer_pkg::ST_IDLE;
      op_q     <= 2'h0;
      set_q    <= 1'b0;
      tstart_q <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      tstart_q <= 1'b0;
      o_done   <= 1'b0;
      case (state_q)
        flash_timer_pkg::ST_IDLE: begin
          // Unknown operation codes are ignored
          if (i_start && op_ok) begin
            op_q     <= i_op;
            set_q    <= i_data_array;
            tstart_q <= 1'b1;
            state_q  <= flash_timer_pkg::ST_SETUP;
          end
        end
        flash_timer_pkg::ST_SETUP: if (tdone) begin
          tstart_q <= 1'b1;
          state_q  <= flash_timer_pkg::ST_TRAN;
        end
        flash_timer_pkg::ST_TRAN: if (tdone) begin
          tstart_q <= 1'b1;
          state_q  <= flash_timer_pkg::ST_PULSE;
        end
        flash_timer_pkg::ST_PULSE: if (tdone) begin
          tstart_q <= 1'b1;
          state_q  <= flash_timer_pkg::ST_HOLD;
        end
        flash_timer_pkg::ST_HOLD: if (tdone) begin
          tstart_q <= 1'b1;
          state_q  <= flash_timer_pkg::ST_RECOVER;
        end
        flash_timer_pkg::ST_RECOVER: if (tdone) begin
          o_done  <= 1'b1;
          state_q <= flash_timer_pkg::ST_IDLE;
        end
        default: state_q <= flash_timer_pkg::ST_IDLE;
      endcase
    end
  end

  // Next values of the registered array controls
  wire in_op     = (state_q != flash_timer_pkg::ST_IDLE)
                && (state_q != flash_timer_pkg::ST_RECOVER);
  wire strobe_d  = (state_q == flash_timer_pkg::ST_TRAN)
                || (state_q == flash_timer_pkg::ST_PULSE)
                || (state_q == flash_timer_pkg::ST_HOLD);
  // Program level covers setup through pulse end
  wire program_d = is_prog && in_op
                && (state_q != flash_timer_pkg::ST_HOLD);
  wire erase_d   = !is_prog && in_op
                && (state_q != flash_timer_pkg::ST_HOLD);

  // Array controls straight from flip-flops; timer start aligns phases
  always_ff @(posedge i_core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_program                  <= 1'b0;
      o_erase                    <= 1'b0;
      o_module_erase             <= 1'b0;
      o_nonvolatile_store_strobe <= 1'b0;
      o_data_array_sel           <= 1'b0;
      o_busy                     <= 1'b0;
    end else begin
      o_program                  <= program_d;
      o_erase                    <= erase_d;
      o_module_erase             <= erase_d && is_module;
      o_nonvolatile_store_strobe <= strobe_d;
      o_data_array_sel           <= set_q;
      o_busy                     <= state_q != flash_timer_pkg::ST_IDLE;
    end
  end

endmodule : flash_program_erase_timer

// File: flash_timer_checker.sv
// Port-level checks on the flash program/erase strobe sequencer.
// Assumes it is bound into flash_program_erase_timer, one clock domain.
`timescale 1ns/100ps
module flash_timer_checker (
  // Clock, reset and command
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  input wire logic       i_start,
  input wire logic [1:0] i_op,
  // Counts used for the timed checks
  input wire logic [7:0] i_main_prescale_reg,
  input wire logic [7:0] i_data_prescale_reg,
  input wire logic [7:0] i_main_strobe_setup_reg,
  input wire logic [7:0] i_data_strobe_setup_reg,
  input wire logic [7:0] i_main_recovery_reg,
  input wire logic [7:0] i_data_recovery_reg,
  // Sequencer outputs
  input wire logic       o_program,
  input wire logic       o_erase,
  input wire logic       o_module_erase,
  input wire logic       o_nonvolatile_store_strobe,
  input wire logic       o_data_array_sel,
  input wire logic       o_busy,
  input wire logic       o_done
);
  wire        act = o_program | o_erase | o_module_erase; // Op line high
  wire        stb = o_nonvolatile_store_strobe;
  wire        ds  = o_data_array_sel;
  // Selected set, each count plus one; slack of 3 covers phase overhead
  wire [8:0]  pre = {1'b0, ds ? i_data_prescale_reg : i_main_prescale_reg};
  wire [8:0]  su  = {1'b0, ds ? i_data_strobe_setup_reg
                              : i_main_strobe_setup_reg};
  wire [8:0]  rc  = {1'b0, ds ? i_data_recovery_reg : i_main_recovery_reg};
  wire [23:0] e_su = (pre + 9'h001) * (su + 9'h001);
  wire [23:0] e_rc = (pre + 9'h001) * (rc + 9'h001);
  logic [23:0] since_q;  // Cycles since last edge of op or strobe
  logic        act_q;
  logic        stb_q;
  // Span counter restarts on any op or strobe edge
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      since_q <= 24'h000000;
      act_q   <= 1'b0;
      stb_q   <= 1'b0;
    end else begin
      act_q   <= act;
      stb_q   <= stb;
      since_q <= (act != act_q || stb != stb_q) ? 24'h000000
                                                : since_q + 24'h000001;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  a_setup_time: assert property ($rose(stb) |->
    since_q + 24'h1 >= e_su && since_q <= e_su + 24'h2)
    else $error("strobe setup span wrong");
  a_recovery_time: assert property ($rose(o_done) |->
    since_q + 24'h1 >= e_rc && since_q <= e_rc + 24'h2)
    else $error("recovery span wrong");
  a_strobe_needs_op: assert property ($rose(stb) |-> act)
    else $error("strobe rose without op");
  a_strobe_outlasts: assert property ($fell(act) |-> stb)
    else $error("strobe gone before pulse end");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_quiet: assert property (o_done |-> !act && !stb)
    else $error("done while array driven");
  // Busy follows the state register, so it shows two edges after start
  a_start_taken: assert property (
    i_start && !o_busy && i_op != 2'h3 |-> ##2 o_busy)
    else $error("start not taken");
  a_bad_op_dropped: assert property (
    i_start && !o_busy && i_op == 2'h3 |-> ##2 !o_busy)
    else $error("reserved op taken");
  a_set_steady: assert property (stb |-> $stable(ds))
    else $error("set changed under strobe");
  c_data_done: cover property ($rose(o_done) && ds);
  c_module_end: cover property ($fell(o_module_erase));
  c_program: cover property ($rose(o_program));
endmodule : flash_timer_checker
bind flash_program_erase_timer flash_timer_checker u_chk (.*);

// File: flash_array_model.sv
// Flash array side: timestamps each control edge in clock cycles.
// Assumes controls change just after the rising clock edge.
`timescale 1ns/100ps
module flash_array_model (
  // Clock and controls
  input  wire logic i_core_clk,
  input  wire logic i_program,
  input  wire logic i_erase,
  input  wire logic i_module_erase,
  input  wire logic i_strobe,
  input  wire logic i_done,
  // Spans of the last operation, and order faults seen
  output int        o_setup,
  output int        o_mid,
  output int        o_hold,
  output int        o_rcv,
  output int        o_bad
);
  int   cyc;             // Free-running cycle count
  int   mark;            // Cycle of the last control edge
  logic act_q = 1'b0;
  logic stb_q = 1'b0;
  wire  act = i_program | i_erase | i_module_erase;
  // Cells need an op line before the strobe, else high voltage misfires
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    act_q <= act;
    stb_q <= i_strobe;
    if (act && !act_q) mark <= cyc;
    if (i_strobe && !stb_q) begin
      o_setup <= cyc - mark;
      mark <= cyc;
      if (!act) o_bad <= o_bad + 1;
    end
    if (!act && act_q) begin
      o_mid <= cyc - mark;
      mark <= cyc;
    end
    if (!i_strobe && stb_q) begin
      o_hold <= cyc - mark;
      mark <= cyc;
    end
    if (i_done) o_rcv <= cyc - mark;
  end
endmodule : flash_array_model

// File: tb_top.sv
// Self-checking bench for the flash program/erase sequencer.
// Assumes the flash array model measures spans at the ports.
`timescale 1ns/100ps
module tb_top;
  logic       clk;
  logic       rst_n;
  logic       start;
  logic [1:0] op;
  logic       sel;
  logic [7:0] m [9];  // Program-array counts
  logic [7:0] d [9];  // Data-array counts
  wire        prog, ers, mers, stb, dsel, busy, done;
  int         t_su, t_mid, t_hd, t_rc, bad;
  int         n_errors;
  int         samples_checked;
  flash_program_erase_timer uut (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_start(start), .i_op(op), .i_data_array(sel),
    .i_main_prescale_reg(m[0]), .i_main_strobe_setup_reg(m[1]),
    .i_main_pulse_setup_reg(m[2]), .i_main_program_pulse_reg(m[3]),
    .i_main_page_erase_reg(m[4]), .i_main_module_erase_reg(m[5]),
    .i_main_strobe_hold_reg(m[6]), .i_main_module_hold_reg(m[7]),
    .i_main_recovery_reg(m[8]),
    .i_data_prescale_reg(d[0]), .i_data_strobe_setup_reg(d[1]),
    .i_data_pulse_setup_reg(d[2]), .i_data_program_pulse_reg(d[3]),
    .i_data_page_erase_reg(d[4]), .i_data_module_erase_reg(d[5]),
    .i_data_strobe_hold_reg(d[6]), .i_data_module_hold_reg(d[7]),
    .i_data_recovery_reg(d[8]),
    .o_program(prog), .o_erase(ers), .o_module_erase(mers),
    .o_nonvolatile_store_strobe(stb), .o_data_array_sel(dsel),
    .o_busy(busy), .o_done(done));
  flash_array_model u_flash (.i_core_clk(clk), .i_program(prog),
    .i_erase(ers), .i_module_erase(mers), .i_strobe(stb), .i_done(done),
    .o_setup(t_su), .o_mid(t_mid), .o_hold(t_hd), .o_rcv(t_rc),
    .o_bad(bad));
  always #12.5 clk = ~clk;
  // Span within slack cycles of its formula
  task automatic check(string name, int e, int slack, int got);
    samples_checked++;
    if (got < e || got > e + slack) begin
      n_errors++;
      $display("CHECK FAILED %s exp %0d seen %0d", name, e, got);
    end
  endtask : check
  task automatic check_bit(string name, logic e, logic got);
    samples_checked++;
    if (got !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %b seen %b", name, e, got);
    end
  endtask : check_bit
  // One whole operation, then each measured span against its formula
  task automatic run(input logic [1:0] k, input logic ds);
    logic [7:0] r [9];
    int p;
    int w;
    int e_pu;
    int e_hd;
    if (ds) begin
      r = d;
    end else begin
      r = m;
    end
    p = r[0] + 1;
    // Measured mid span covers strobe-to-pulse setup plus the pulse
    if (k == 2'h0) begin
      e_pu = p * (r[2] + 1) + p * 8 * (r[3] + 1);
    end else if (k == 2'h1) begin
      e_pu = p * (r[2] + 1) + p * 4096 * (r[4] + 1);
    end else begin
      e_pu = p * (r[2] + 1) + p * 4096 * (r[5] + 1);
    end
    if (k == 2'h2) begin
      e_hd = p * 8 * (r[7] + 1);
    end else begin
      e_hd = p * (r[6] + 1);
    end
    @(posedge clk);
    #1 op = k;
    sel = ds;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    @(posedge clk);
    #1;
    check_bit("busy", 1'b1, busy);
    check_bit("set", ds, dsel);
    check_bit("program", k == 2'h0, prog);
    check_bit("erase", k != 2'h0, ers);
    check_bit("module", k == 2'h2, mers);
    w = 0;
    while (done !== 1'b1 && w < 40000) begin
      @(posedge clk);
      #1 w++;
    end
    // A wait that runs out counts as a mismatch
    check("done wait", 0, 39999, w);
    @(posedge clk);
    #1;
    check("setup", p * (r[1] + 1), 3, t_su);
    check("pulse", e_pu, 6, t_mid);
    check("hold", e_hd, 3, t_hd);
    check("recovery", p * (r[8] + 1), 3, t_rc);
    check("order", 0, 0, bad);
  endtask : run
  task automatic test_main_program;
    run(2'h0, 1'b0);
  endtask : test_main_program
  task automatic test_data_program;
    run(2'h0, 1'b1);
  endtask : test_data_program
  task automatic test_page_erase;
    run(2'h1, 1'b0);
  endtask : test_page_erase
  task automatic test_module_erase;
    run(2'h2, 1'b1);
  endtask : test_module_erase
  // Reserved op code must leave the sequencer idle
  task automatic test_reserved_op;
    @(posedge clk);
    #1 op = 2'h3;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    repeat (2) @(posedge clk);
    #1 check_bit("idle", 1'b0, busy);
  endtask : test_reserved_op
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    start = 1'b0;
    op = 2'h0;
    sel = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    // Short program pulses keep row exposure far below the cap
    m = '{8'h01, 8'h04, 8'h02, 8'h01, 8'h00,
          8'h00, 8'h03, 8'h00, 8'h02};
    d = '{8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    test_reserved_op();
    test_main_program();
    test_data_program();
    test_page_erase();
    test_module_erase();
    print_verdict();
  end
  // Watchdog well past the expected ~21000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule : tb_top
